// ==== rtl/ucs_pkg.sv ====
package ucs_pkg;
	// register indices (printed offsets absent, chosen here)
	localparam logic [3:0] ADDR_MODE   = 4'h0;
	localparam logic [3:0] ADDR_CTRL   = 4'h1;
	localparam logic [3:0] ADDR_BAUD   = 4'h2;
	localparam logic [3:0] ADDR_TXBUF  = 4'h3;
	localparam logic [3:0] ADDR_RXBUF  = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h5;
	localparam logic [3:0] ADDR_IRQ    = 4'h6;
	// serial mode field encodings
	localparam logic [2:0] MODE_OFF    = 3'h0;
	localparam logic [2:0] MODE_CLKD   = 3'h1;
	localparam logic [2:0] MODE_BUS    = 3'h6;
	localparam logic [2:0] MODE_CARD   = 3'h5;
	// mode register field positions
	localparam int MB_CLOCK_SOURCE_SELECT = 3;
	localparam int MB_STOP_BIT_COUNT  = 4;
	localparam int MB_PRY   = 5;
	localparam int MB_PARITY_ENABLE  = 6;
	// control register field positions
	localparam int CB_TXEN  = 0;
	localparam int CB_RXEN  = 1;
	localparam int CB_IRS   = 2;
	localparam int CB_ERE   = 3;
	localparam int CB_ORDER = 4;
	localparam int CB_INV   = 5;
	localparam int CB_CLOCK_PHASE_SELECT  = 6;
	localparam int CB_CLOCK_POLARITY_SELECT = 7;
	localparam int CB_COLLISION_SAMPLE_SELECT = 8;
	localparam int CB_TX_ENABLE_AUTOCLEAR  = 9;
	localparam int CB_SSS   = 10;
	localparam int CB_CE0   = 11;
	localparam int CB_CE1   = 12;
	// irq register bits: tx, rx, collision; write 1 clears
	localparam int IB_TX  = 0;
	localparam int IB_RX  = 1;
	localparam int IB_COL = 2;
	localparam logic [3:0] OVS = 4'hf;     // 16 ticks per bit, minus one
	localparam logic [3:0] CHAR_BITS = 4'hb; // start, 9 data/parity, stop
	localparam logic [1:0] CHAN_ID = 2'h2;
	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_WAIT = 3'b010,
		TX_SEND = 3'b100
	} ucs_txst_t;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b01,
		RX_RECV = 2'b10
	} ucs_rxst_t;
	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} ucs_bus_t;
	typedef struct packed {
		logic [7:0]  mode;
		logic [12:0] ctrl;
		logic [7:0]  baud;
		logic [8:0]  txbuf;
		logic        tx_empty;
		logic [8:0]  rxbuf;
		logic        rx_full;
		logic        ovr;
		logic        frm;
		logic        par;
		logic [2:0]  irq;
		logic [7:0]  bdiv;
		logic [3:0]  tick;
		logic        bclk_pulse;
		logic        ext_q;
		ucs_txst_t   txst;
		logic [10:0] tsh;
		logic [3:0]  tcnt;
		logic        txd;
		logic        sin_q;
		ucs_rxst_t   rxst;
		logic [3:0]  rtick;
		logic [3:0]  rcnt;
		logic [9:0]  rsh;
		logic        err_sig;
		logic        tout;
		logic [15:0] rdata;
		logic        irq_out;
	} ucs_state_t;
endpackage

// ==== rtl/ucs_core.sv ====
`timescale 1ns/1ps
module ucs_core (
	input  wire logic            clk,
	input  wire logic            rst_n,
	input  wire ucs_pkg::ucs_bus_t bus,
	output logic [15:0]          rd_data,
	input  wire logic            serial_in_pin,
	input  wire logic            ext_clock_pin,
	input  wire logic            timer_underflow,
	output logic                 serial_out_pin,
	output logic                 irq_request
);
	ucs_pkg::ucs_state_t s_r;
	ucs_pkg::ucs_state_t s_nxt;
	logic card;
	logic busm;
	logic inv;
	logic cmp_en;
	logic [8:0] txd_w;
	logic [7:0] rdat;
	logic       rpar;
	logic       coll;
	logic       adv;

	// channel 2 needs no enable bit; channels 0 and 1 do
	localparam logic CHAN_ID_OK = ucs_pkg::CHAN_ID == 2'h2;

	// mode decode
	assign card = s_r.mode[2:0] == ucs_pkg::MODE_CARD;
	assign busm = s_r.mode[2:0] == ucs_pkg::MODE_BUS;
	assign inv  = s_r.ctrl[ucs_pkg::CB_INV];

	// collision judged on each bit clock pulse or at timer underflow
	assign cmp_en = s_r.ctrl[ucs_pkg::CB_COLLISION_SAMPLE_SELECT] ? timer_underflow : s_r.bclk_pulse;
	assign coll = busm && s_r.txst == ucs_pkg::TX_SEND && cmp_en
		&& (s_r.txd != serial_in_pin);

	// bit-reversed received data for msb-first
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			rdat[i] = s_r.ctrl[ucs_pkg::CB_ORDER] ? s_r.rsh[8 - i] : s_r.rsh[1 + i];
		end
		rpar = ^s_r.rsh[9:1] ^ s_r.mode[ucs_pkg::MB_PRY]; // 1 means parity good
		txd_w = 9'h000;
		for (int i = 0; i < 8; i++) begin
			txd_w[i] = s_r.ctrl[ucs_pkg::CB_ORDER] ? s_r.txbuf[7 - i] : s_r.txbuf[i];
		end
		txd_w[8] = s_r.mode[ucs_pkg::MB_PARITY_ENABLE] ?
			(^s_r.txbuf[7:0] ^ ~s_r.mode[ucs_pkg::MB_PRY]) : s_r.txbuf[8];
	end

	// whole block next state
	always_comb begin
		s_nxt = s_r;
		adv = 1'b0;
		s_nxt.bclk_pulse = 1'b0;
		s_nxt.ext_q = ext_clock_pin;
		s_nxt.sin_q = serial_in_pin;
		// baud: source divided by n+1, then 16 ticks per bit
		if (!s_r.mode[ucs_pkg::MB_CLOCK_SOURCE_SELECT] || (ext_clock_pin && !s_r.ext_q)) begin
			if (s_r.bdiv == 8'h00) begin
				s_nxt.bdiv = s_r.baud;
				s_nxt.tick = s_r.tick + 4'h1;
				adv = 1'b1; // one 16x tick per advance, whatever the source
				if (s_r.tick == ucs_pkg::OVS) begin
					s_nxt.bclk_pulse = 1'b1;
				end
			end else begin
				s_nxt.bdiv = s_r.bdiv - 8'h01;
			end
		end
		// transmitter
		case (s_r.txst)
			ucs_pkg::TX_IDLE: begin
				if (s_r.ctrl[ucs_pkg::CB_TXEN] && !s_r.tx_empty) begin
					s_nxt.txst = ucs_pkg::TX_WAIT;
				end
			end
			ucs_pkg::TX_WAIT: begin
				if (!s_r.ctrl[ucs_pkg::CB_TXEN]) begin
					s_nxt.txst = ucs_pkg::TX_IDLE;
				end else if (busm && s_r.ctrl[ucs_pkg::CB_SSS] ?
						(serial_in_pin && !s_r.sin_q) : s_r.bclk_pulse) begin
					s_nxt.txst = ucs_pkg::TX_SEND;
					s_nxt.tsh = {1'b1, txd_w, 1'b0}; // one char per bus bit
					s_nxt.tcnt = 4'h0;
					s_nxt.tx_empty = 1'b1;
				end
			end
			ucs_pkg::TX_SEND: begin
				if (s_r.bclk_pulse) begin
					s_nxt.txd = s_r.tsh[0] ^ (inv && s_r.tcnt != 4'h0
						&& s_r.tcnt != ucs_pkg::CHAR_BITS - 4'h1);
					s_nxt.tsh = {1'b1, s_r.tsh[10:1]};
					s_nxt.tcnt = s_r.tcnt + 4'h1;
					// one pulse past the stop bit: finish, keep the line high
					if (s_r.tcnt == ucs_pkg::CHAR_BITS) begin
						s_nxt.txst = ucs_pkg::TX_IDLE;
						s_nxt.txd = 1'b1;
						// raised on the edge after stop
						if (s_r.ctrl[ucs_pkg::CB_IRS]) begin
							s_nxt.irq[ucs_pkg::IB_TX] = 1'b1;
						end
					end
				end
			end
			default: s_nxt.txst = ucs_pkg::TX_IDLE;
		endcase
		if (s_r.txst != ucs_pkg::TX_SEND) begin
			s_nxt.txd = 1'b1;
		end
		// receiver: mid-bit sampling on 16x tick
		case (s_r.rxst)
			ucs_pkg::RX_IDLE: begin
				if (s_r.ctrl[ucs_pkg::CB_RXEN] && !serial_in_pin && !busm) begin
					s_nxt.rxst = ucs_pkg::RX_RECV;
					s_nxt.rtick = s_r.tick + 4'h8;
					s_nxt.rcnt = 4'h0;
				end
			end
			ucs_pkg::RX_RECV: begin
				// sample once per bit, only on the cycle the tick advances
				if (adv && s_r.tick == s_r.rtick) begin
					s_nxt.rsh = {serial_in_pin ^ (inv && s_r.rcnt != 4'h0), s_r.rsh[9:1]};
					s_nxt.rcnt = s_r.rcnt + 4'h1;
					if (s_r.rcnt == ucs_pkg::CHAR_BITS - 4'h2 && s_r.rx_full) begin
						s_nxt.ovr = 1'b1;
					end
					if (s_r.rcnt == ucs_pkg::CHAR_BITS - 4'h1) begin
						s_nxt.rxst = ucs_pkg::RX_IDLE;
						s_nxt.frm = s_r.frm | !serial_in_pin;
						if (!s_r.rx_full) begin
							s_nxt.rxbuf = {s_r.rsh[9], rdat};
							s_nxt.rx_full = 1'b1;
							s_nxt.irq[ucs_pkg::IB_RX] = 1'b1;
							if (s_r.mode[ucs_pkg::MB_PARITY_ENABLE] && !rpar) begin
								s_nxt.par = 1'b1;
								if (s_r.ctrl[ucs_pkg::CB_ERE] && card) begin
									s_nxt.err_sig = 1'b1;
								end
							end
						end
					end
				end
			end
			default: s_nxt.rxst = ucs_pkg::RX_IDLE;
		endcase
		// bus writes; hardware sets above win over clears
		if (bus.wr) begin
			case (bus.addr)
				ucs_pkg::ADDR_MODE: s_nxt.mode = bus.wdata[7:0];
				ucs_pkg::ADDR_CTRL: s_nxt.ctrl = bus.wdata[12:0];
				ucs_pkg::ADDR_BAUD: s_nxt.baud = bus.wdata[7:0];
				ucs_pkg::ADDR_TXBUF: begin
					s_nxt.txbuf = bus.wdata[8:0];
					s_nxt.tx_empty = 1'b0;
				end
				ucs_pkg::ADDR_IRQ: s_nxt.irq = s_r.irq & ~bus.wdata[2:0] | (s_nxt.irq & ~s_r.irq);
				default: ;
			endcase
		end
		// collision flag and autoclear of transmit enable
		if (coll && (s_r.ctrl[ucs_pkg::CB_CE0] || s_r.ctrl[ucs_pkg::CB_CE1]
				|| CHAN_ID_OK)) begin
			s_nxt.irq[ucs_pkg::IB_COL] = 1'b1;
			if (s_r.ctrl[ucs_pkg::CB_TX_ENABLE_AUTOCLEAR]) begin
				s_nxt.ctrl[ucs_pkg::CB_TXEN] = 1'b0;
			end
		end
		// read data, one cycle later
		s_nxt.rdata = 16'h0000;
		if (bus.rd) begin
			case (bus.addr)
				ucs_pkg::ADDR_MODE:   s_nxt.rdata = {8'h00, s_r.mode};
				ucs_pkg::ADDR_CTRL:   s_nxt.rdata = {3'h0, s_r.ctrl};
				ucs_pkg::ADDR_BAUD:   s_nxt.rdata = {8'h00, s_r.baud};
				ucs_pkg::ADDR_TXBUF:  s_nxt.rdata = {7'h00, s_r.txbuf};
				ucs_pkg::ADDR_RXBUF: begin
					s_nxt.rdata = {7'h00, s_r.rxbuf};
					s_nxt.rx_full = 1'b0;
					s_nxt.err_sig = 1'b0;
					if (s_r.err_sig) begin
						s_nxt.par = 1'b0;
					end
				end
				ucs_pkg::ADDR_STATUS: s_nxt.rdata = {9'h000, s_r.tx_empty, s_r.rx_full,
					s_r.ovr | s_r.frm | s_r.par, s_r.par, s_r.frm, s_r.ovr,
					serial_in_pin}; // bit 0 is the input line level; sum flag is bit 4
				ucs_pkg::ADDR_IRQ:    s_nxt.rdata = {13'h0000, s_r.irq};
				default:              s_nxt.rdata = 16'h0000;
			endcase
		end
		s_nxt.tout = s_nxt.txd & ~s_nxt.err_sig;
		s_nxt.irq_out = |s_nxt.irq;
	end

	// state register; reset leaves tx buffer empty and line idle high
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r          <= '0;
			s_r.txst     <= ucs_pkg::TX_IDLE;
			s_r.rxst     <= ucs_pkg::RX_IDLE;
			s_r.tx_empty <= 1'b1;
			s_r.txd      <= 1'b1;
			s_r.tout     <= 1'b1;
			s_r.sin_q    <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rd_data        = s_r.rdata;
	assign serial_out_pin = s_r.tout;
	assign irq_request    = s_r.irq_out;

	// parity error signal released on buffer read
	a_err_release: assert property (@(posedge clk) disable iff (!rst_n)
		bus.rd && bus.addr == ucs_pkg::ADDR_RXBUF && s_r.err_sig |=> serial_out_pin
		|| s_r.txd == 1'b0)
		else $error("error signal not released");
	a_autoclear: assert property (@(posedge clk) disable iff (!rst_n)
		coll && s_r.ctrl[ucs_pkg::CB_TX_ENABLE_AUTOCLEAR] && !bus.wr |=> !s_r.ctrl[ucs_pkg::CB_TXEN])
		else $error("tx enable not cleared");
	a_tx_start: assert property (@(posedge clk) disable iff (!rst_n)
		s_r.txst == ucs_pkg::TX_IDLE && $past(s_r.tx_empty) |=> s_r.txst != ucs_pkg::TX_SEND)
		else $error("tx started without data");
	a_rx_irq: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(s_r.irq[ucs_pkg::IB_RX]) |-> $rose(s_r.rx_full))
		else $error("rx irq without buffer load");
	a_err_low: assert property (@(posedge clk) disable iff (!rst_n)
		s_r.err_sig |-> !serial_out_pin)
		else $error("error signal not driven low");
	a_sum_flag: assert property (@(posedge clk) disable iff (!rst_n)
		bus.rd && bus.addr == ucs_pkg::ADDR_STATUS |=> rd_data[4] == (rd_data[1] | rd_data[2]
		| rd_data[3]))
		else $error("sum flag mismatch");
	a_coll_flag: assert property (@(posedge clk) disable iff (!rst_n)
		coll |=> s_r.irq[ucs_pkg::IB_COL])
		else $error("collision not flagged");
	a_idle_high: assert property (@(posedge clk) disable iff (!rst_n)
		(s_r.txst == ucs_pkg::TX_IDLE && !s_r.err_sig) [*2] |-> serial_out_pin)
		else $error("line not idle high");

	// start timing, on the next bit clock pulse after enable or at input rising edge
	a_start_tick: assert property (@(posedge clk) disable iff (!rst_n)
		s_r.txst == ucs_pkg::TX_SEND && $past(s_r.txst) == ucs_pkg::TX_WAIT
		&& !$past(busm && s_r.ctrl[ucs_pkg::CB_SSS]) |-> $past(s_r.bclk_pulse))
		else $error("start not on bit clock");
	a_start_edge: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(s_r.txst == ucs_pkg::TX_SEND) && $past(busm && s_r.ctrl[ucs_pkg::CB_SSS])
		|-> $past(serial_in_pin) && !$past(s_r.sin_q))
		else $error("start not on input edge");
	a_rx_start: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(s_r.rxst == ucs_pkg::RX_RECV) |-> $past(s_r.ctrl[ucs_pkg::CB_RXEN])
		&& !$past(serial_in_pin))
		else $error("rx started without start bit");
	a_tx_done: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(s_r.irq[ucs_pkg::IB_TX]) |-> $past(s_r.ctrl[ucs_pkg::CB_IRS])
		&& $past(s_r.txst) == ucs_pkg::TX_SEND)
		else $error("tx request without finish");
	a_ovr_set: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(s_r.ovr) |-> $past(s_r.rx_full))
		else $error("overrun without full buffer");
	a_ovr_irq: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(s_r.ovr) && !$past(bus.wr)
		|-> s_r.irq[ucs_pkg::IB_RX] == $past(s_r.irq[ucs_pkg::IB_RX]))
		else $error("rx request changed on overrun");
	a_frm_set: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(s_r.frm) |-> !$past(serial_in_pin))
		else $error("framing flag without low stop");
	a_card_only: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(s_r.err_sig) |-> $past(card))
		else $error("error signal outside card mode");

	// buffer read during error signal, then flag and signal gone
	sequence s_buf_read_err;
		bus.rd && bus.addr == ucs_pkg::ADDR_RXBUF && s_r.err_sig;
	endsequence
	sequence s_par_cleared;
		!s_r.par && !s_r.err_sig;
	endsequence
	a_par_clear: assert property (@(posedge clk) disable iff (!rst_n)
		s_buf_read_err |=> s_par_cleared)
		else $error("parity flag not cleared");
endmodule

// ==== bench/ucs_card.sv ====
`timescale 1ns/1ps
// card side of a pulled-up line that either party may pull low
module ucs_card (
	input  wire logic clk,
	input  wire logic out_pin,
	output logic      line
);
	logic drv = 1'b1;
	// wired-and with pull-up: a released line reads high, never a stale level
	assign line = out_pin & drv;
	// hold the card's own pull at a fixed level
	task automatic hold(input logic v);
		drv <= v;
	endtask
	// one frame, f[0] first, per clocks a bit; released afterwards
	task automatic send(input logic [10:0] f, input int per);
		for (int i = 0; i < 11; i++) begin
			drv <= f[i];
			repeat (per) @(posedge clk);
		end
		drv <= 1'b1;
	endtask
	// sample mid-bit on falling clock edges, clear of the launch edge
	task automatic recv(input int per, output logic [10:0] f);
		int k;
		k = 0;
		f = '0;
		while (line !== 1'b0 && k < 5000) begin
			@(negedge clk);
			k++;
		end
		repeat (per / 2) @(negedge clk);
		for (int i = 0; i < 11; i++) begin
			f[i] = line;
			repeat (per) @(negedge clk);
		end
	endtask
endmodule

// ==== bench/test_uart_collision_and_smartcard_modes.sv ====
`timescale 1ns/1ps
module test_uart_collision_and_smartcard_modes;
	logic              clk;
	logic              rst_n;
	ucs_pkg::ucs_bus_t bus;
	logic [15:0]       rd_data;
	logic              serial_in_pin;
	logic              ext_clock_pin;
	logic              timer_underflow;
	logic              serial_out_pin;
	logic              irq_request;
	int                n_fail = 0;
	int                n_tests = 0;
	int                cyc = 0;
	logic [15:0]       r;
	logic [10:0]       f;

	ucs_core u_dut (
		.clk            (clk),
		.rst_n          (rst_n),
		.bus            (bus),
		.rd_data        (rd_data),
		.serial_in_pin  (serial_in_pin),
		.ext_clock_pin  (ext_clock_pin),
		.timer_underflow(timer_underflow),
		.serial_out_pin (serial_out_pin),
		.irq_request    (irq_request)
	);
	ucs_card u_card (.clk(clk), .out_pin(serial_out_pin), .line(serial_in_pin));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// external clock at clk/8, timer pulse every 8 cycles, run ceiling
	always @(posedge clk) begin
		cyc <= cyc + 1;
		ext_clock_pin <= cyc[2];
		timer_underflow <= (cyc[2:0] == 3'h7);
		if (cyc == 40000) begin
			n_fail++;
			conclude();
		end
	end

	task automatic conclude();
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 r = rd_data;
	endtask
	task automatic do_reset();
		u_card.hold(1'b1);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
	endtask
	task automatic setup(input logic [15:0] m, c, b);
		wr(ucs_pkg::ADDR_MODE, m);
		wr(ucs_pkg::ADDR_BAUD, b);
		wr(ucs_pkg::ADDR_CTRL, c);
		wr(ucs_pkg::ADDR_IRQ, 16'h0007);
	endtask
	function automatic logic [10:0] frame(input logic [7:0] d, input logic p, s);
		return {s, p, d, 1'b0};
	endfunction

	task automatic reg_test();
		do_reset();
		rd(ucs_pkg::ADDR_STATUS);
		chk(r, 16'h0041, "status after reset");
		for (int k = 0; k < 4; k++) begin
			wr(ucs_pkg::ADDR_CTRL, 16'(k) << ucs_pkg::CB_CLOCK_PHASE_SELECT);
			rd(ucs_pkg::ADDR_CTRL);
			chk(r, 16'(k) << ucs_pkg::CB_CLOCK_PHASE_SELECT, "phase and polarity");
		end
		wr(4'hf, 16'h00ff);
		rd(4'hf);
		chk(r, 16'h0000, "unmapped read");
		$display("done registers");
	endtask
	// held data must wait for the enable, then leave framed at 16(n+1)
	task automatic tx_test(input logic [15:0] m, c, b, input int per,
			input logic [10:0] e, input logic [10:0] msk);
		do_reset();
		setup(m, c & 16'hfffe, b);
		wr(ucs_pkg::ADDR_TXBUF, 16'h0035);
		repeat (per * 2) @(posedge clk);
		chk(16'(serial_out_pin), 16'h0001, "sent without enable");
		wr(ucs_pkg::ADDR_CTRL, c);
		u_card.recv(per, f);
		chk(16'(f & msk), 16'(e & msk), "line frame");
		repeat (per) @(posedge clk);
		rd(ucs_pkg::ADDR_IRQ);
		chk(r & 16'h0001, 16'h0001, "transmit done request");
		$display("done transmit");
	endtask
	task automatic rx_test(input logic [10:0] fr, input int n, input logic [15:0] m);
		do_reset();
		setup(16'h0065, 16'h000e, 16'h0000);
		repeat (n) u_card.send(fr, 16);
		repeat (24) @(posedge clk);
		rd(ucs_pkg::ADDR_STATUS);
		chk(r & m, m, "status flags");
	endtask
	// card pulls the line low while the channel sends ones
	task automatic col_test(input logic [15:0] c);
		do_reset();
		setup(16'h0006, c, 16'h0000);
		u_card.hold(1'b0);
		wr(ucs_pkg::ADDR_TXBUF, 16'h01ff);
		repeat (300) @(posedge clk);
		u_card.hold(1'b1);
		rd(ucs_pkg::ADDR_IRQ);
		chk(r & 16'h0004, 16'h0004, "collision request");
		rd(ucs_pkg::ADDR_CTRL);
		chk(r & 16'h0001, 16'h0000, "enable cleared");
		$display("done collision");
	endtask
	task automatic start_test();
		do_reset();
		setup(16'h0006, 16'h0401, 16'h0000);
		u_card.hold(1'b0);
		wr(ucs_pkg::ADDR_TXBUF, 16'h01ff);
		repeat (100) @(posedge clk);
		u_card.hold(1'b1);
		chk(16'(serial_out_pin), 16'h0001, "early start");
		u_card.recv(16, f);
		chk(16'(f), 16'h07fe, "bus bit character");
		$display("done start select");
	endtask

	initial begin
		bus = '0;
		rst_n = 1'b0;
		reg_test();
		tx_test(16'h0065, 16'h000f, 16'h0001, 32, frame(8'h35, 1'b0, 1'b1), 11'h7ff);
		tx_test(16'h0045, 16'h003f, 16'h0001, 32, frame(8'h53, 1'b0, 1'b1), 11'h5ff);
		tx_test(16'h006d, 16'h000f, 16'h0000, 128, frame(8'h35, 1'b0, 1'b1), 11'h7ff);
		rx_test(frame(8'h35, 1'b0, 1'b1), 1, 16'h0020);
		rd(ucs_pkg::ADDR_IRQ);
		chk(r & 16'h0002, 16'h0002, "receive request");
		rd(ucs_pkg::ADDR_RXBUF);
		chk(r & 16'h00ff, 16'h0035, "received byte");
		rx_test(frame(8'h35, 1'b1, 1'b1), 1, 16'h0018);
		chk(16'(serial_out_pin), 16'h0000, "error signal");
		rd(ucs_pkg::ADDR_RXBUF);
		chk(16'(serial_out_pin), 16'h0001, "error signal released");
		rd(ucs_pkg::ADDR_STATUS);
		chk(r & 16'h0008, 16'h0000, "parity flag cleared");
		rx_test(frame(8'h35, 1'b0, 1'b1), 2, 16'h0012);
		rx_test(frame(8'h35, 1'b0, 1'b0), 1, 16'h0014);
		$display("done receive");
		col_test(16'h0201);
		col_test(16'h0301);
		start_test();
		conclude();
	end
endmodule
